// ===== rtl/iod_pkg.sv
package iod_pkg;

    // ************************************************************
    // Register page offsets (5-bit page address)
    // ************************************************************
    localparam logic [4:0] ADDR_PORT_A = 5'h00;
    localparam logic [4:0] ADDR_PORT_B = 5'h01;
    localparam logic [4:0] ADDR_PORT_C = 5'h02;
    localparam logic [4:0] ADDR_PORT_D = 5'h03;
    localparam logic [4:0] ADDR_EXT_FIRST = 5'h04;
    localparam logic [4:0] ADDR_EXT_LAST = 5'h0f;
    localparam logic [4:0] ADDR_ALL_ONES = 5'h10;
    localparam logic [4:0] ADDR_IRQ_FLAGS = 5'h11;
    localparam logic [4:0] ADDR_IRQ_ENABLES = 5'h12;
    localparam logic [4:0] ADDR_MODE_CTRL = 5'h14;
    localparam logic [4:0] ADDR_SER_CTRL = 5'h15;
    localparam logic [4:0] ADDR_SER_STATUS = 5'h16;
    localparam logic [4:0] ADDR_SER_DATA = 5'h17;
    localparam logic [4:0] ADDR_T1_LATCH_LO = 5'h18;
    localparam logic [4:0] ADDR_T1_LOW_CLR = 5'h19;
    localparam logic [4:0] ADDR_T1_HIGH_LOAD = 5'h1a;
    localparam logic [4:0] ADDR_T1_COUNT_LO = 5'h1b;
    localparam logic [4:0] ADDR_T2_LATCH_LO = 5'h1c;
    localparam logic [4:0] ADDR_T2_LOW_CLR = 5'h1d;
    localparam logic [4:0] ADDR_T2_HIGH_LOAD = 5'h1e;
    localparam logic [4:0] ADDR_T2_COUNT_LO = 5'h1f;

    // ************************************************************
    // Field positions, fixed values and reset values
    // ************************************************************
    localparam int SER_WR_BIT_LO = 4;
    localparam int SER_WR_BIT_HI = 5;
    localparam logic [7:0] ALL_ONES_VALUE = 8'hff;
    localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [1:0] SER_BITS_RESET = 2'h0;

    // ************************************************************
    // Timing: external read waits out the two-stage pin synchroniser
    // ************************************************************
    localparam logic [1:0] EXT_RD_WAIT = 2'h3;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic sel;
        logic wr;
        logic [4:0] addr;
        logic [7:0] wdata;
    } iod_req_t;

    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
    } iod_word_t;

    typedef struct packed {
        logic load;
        logic flag_clr;
    } iod_tmr_cmd_t;

endpackage : iod_pkg

// ===== rtl/iod_regs.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Writing 0x1E loads timer two's upper latch byte, moves the latch into its counter and clears its flag.
// - Writing 0x1D loads timer two's upper latch byte and copies the latch into latch C; 0x1C loads the low byte.
// - Writing 0x1A loads timer one's upper latch byte, loads its counter, clears its flag; 0x19/0x18 load only.
// - Reading 0x1F and 0x1D returns timer two's low count, 0x1E its high count, and 0x1D also clears its flag.
// - Reading 0x1B and 0x19 returns timer one's low count, 0x1A its high count, and 0x19 also clears its flag.
// - Address 0x17 reads the serial receive data and writes the separate serial transmit data.
// - The serial status at 0x16 reads in full while writes change only bits 4 and 5.
// - Serial control at 0x15 and mode control at 0x14 are plain read/write registers.
// - Addresses 0x04 to 0x0F are not internal and run as read or write cycles on the external data bus.
module iod_regs (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire iod_pkg::iod_req_t req_i,
    output logic busy_o,
    output logic ack_o,
    output logic [7:0] rdata_o,
    output logic ext_rd_o,
    output logic ext_wr_o,
    output logic [4:0] ext_addr_o,
    output logic [7:0] ext_wdata_o,
    input wire logic [7:0] ext_rdata_i,
    output logic [7:0] port_a_o,
    output logic [7:0] port_b_o,
    output logic [7:0] port_c_o,
    output logic [7:0] port_d_o,
    input wire logic [7:0] irq_flags_i,
    output logic [7:0] irq_enables_o,
    output logic [7:0] mode_ctrl_o,
    output logic [7:0] ser_ctrl_o,
    input wire logic [7:0] ser_status_i,
    output logic [1:0] ser_status_bits_o,
    input wire logic [7:0] ser_rx_data_i,
    output logic ser_rx_read_o,
    output logic [7:0] ser_tx_data_o,
    output logic ser_tx_load_o,
    output iod_pkg::iod_word_t t1_latch_o,
    output iod_pkg::iod_tmr_cmd_t t1_cmd_o,
    input wire iod_pkg::iod_word_t t1_count_i,
    output iod_pkg::iod_word_t t2_latch_o,
    output iod_pkg::iod_word_t t2_latch_c_o,
    output iod_pkg::iod_tmr_cmd_t t2_cmd_o,
    input wire iod_pkg::iod_word_t t2_count_i
);

    // ************************************************************
    // Access decode
    // ************************************************************
    logic [1:0] ext_wait_reg;
    logic [7:0] ext_sync1_reg;
    logic [7:0] ext_sync2_reg;
    logic take;
    logic wr;
    logic rd;
    logic is_ext;
    logic [7:0] rd_mux;

    // A new request is ignored while an external read is still waiting
    assign take = req_i.sel && (ext_wait_reg == 2'h0);
    assign wr = take && req_i.wr;
    assign rd = take && !req_i.wr;
    assign is_ext = (req_i.addr >= iod_pkg::ADDR_EXT_FIRST) && (req_i.addr <= iod_pkg::ADDR_EXT_LAST);

    // ************************************************************
    // Read multiplexer
    // ************************************************************
    // Counters are sampled straight from the timer logic on the same clock
    always_comb begin
        unique case (req_i.addr)
            iod_pkg::ADDR_PORT_A: rd_mux = port_a_o;
            iod_pkg::ADDR_PORT_B: rd_mux = port_b_o;
            iod_pkg::ADDR_PORT_C: rd_mux = port_c_o;
            iod_pkg::ADDR_PORT_D: rd_mux = port_d_o;
            iod_pkg::ADDR_ALL_ONES: rd_mux = iod_pkg::ALL_ONES_VALUE;
            iod_pkg::ADDR_IRQ_FLAGS: rd_mux = irq_flags_i;
            iod_pkg::ADDR_IRQ_ENABLES: rd_mux = irq_enables_o;
            iod_pkg::ADDR_MODE_CTRL: rd_mux = mode_ctrl_o;
            iod_pkg::ADDR_SER_CTRL: rd_mux = ser_ctrl_o;
            iod_pkg::ADDR_SER_STATUS: begin
                rd_mux = {ser_status_i[7:6], ser_status_bits_o, ser_status_i[3:0]};
            end
            iod_pkg::ADDR_SER_DATA: rd_mux = ser_rx_data_i;
            iod_pkg::ADDR_T1_LOW_CLR: rd_mux = t1_count_i.lo;
            iod_pkg::ADDR_T1_HIGH_LOAD: rd_mux = t1_count_i.hi;
            iod_pkg::ADDR_T1_COUNT_LO: rd_mux = t1_count_i.lo;
            iod_pkg::ADDR_T2_LOW_CLR: rd_mux = t2_count_i.lo;
            iod_pkg::ADDR_T2_HIGH_LOAD: rd_mux = t2_count_i.hi;
            iod_pkg::ADDR_T2_COUNT_LO: rd_mux = t2_count_i.lo;
            default: rd_mux = iod_pkg::UNMAPPED_VALUE; // Write-only, reserved, external
        endcase
    end

    // ************************************************************
    // Bus answer
    // ************************************************************
    // Internal accesses and external writes answer at the next edge
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_o <= 1'b0;
            rdata_o <= iod_pkg::RESET_BYTE;
        end else if (ext_wait_reg == 2'h1) begin
            ack_o <= 1'b1;
            rdata_o <= ext_sync2_reg;
        end else if (take && !(rd && is_ext)) begin
            ack_o <= 1'b1;
            rdata_o <= req_i.wr ? iod_pkg::UNMAPPED_VALUE : rd_mux;
        end else begin
            ack_o <= 1'b0;
        end
    end

    // ************************************************************
    // External data bus cycles
    // ************************************************************
    // Read strobe is held while the pin data walks through the synchroniser
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ext_wait_reg <= 2'h0;
            ext_rd_o <= 1'b0;
            ext_wr_o <= 1'b0;
            ext_addr_o <= 5'h00;
            ext_wdata_o <= iod_pkg::RESET_BYTE;
            busy_o <= 1'b0;
        end else begin
            ext_wr_o <= wr && is_ext;
            if (take && is_ext) begin
                ext_addr_o <= req_i.addr;
                ext_wdata_o <= req_i.wdata;
            end
            if (rd && is_ext) begin
                ext_wait_reg <= iod_pkg::EXT_RD_WAIT;
                ext_rd_o <= 1'b1;
                busy_o <= 1'b1;
            end else if (ext_wait_reg != 2'h0) begin
                ext_wait_reg <= ext_wait_reg - 2'h1;
                ext_rd_o <= (ext_wait_reg != 2'h1);
                busy_o <= (ext_wait_reg != 2'h1);
            end
        end
    end

    // Pin data passes two flops; only the second is read by the answer
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ext_sync1_reg <= iod_pkg::RESET_BYTE;
            ext_sync2_reg <= iod_pkg::RESET_BYTE;
        end else begin
            ext_sync1_reg <= ext_rdata_i;
            ext_sync2_reg <= ext_sync1_reg;
        end
    end

    // ************************************************************
    // Port, interrupt enable, mode and serial registers
    // ************************************************************
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            port_a_o <= iod_pkg::RESET_BYTE;
            port_b_o <= iod_pkg::RESET_BYTE;
            port_c_o <= iod_pkg::RESET_BYTE;
            port_d_o <= iod_pkg::RESET_BYTE;
            irq_enables_o <= iod_pkg::RESET_BYTE;
            mode_ctrl_o <= iod_pkg::RESET_BYTE;
            ser_ctrl_o <= iod_pkg::RESET_BYTE;
            ser_status_bits_o <= iod_pkg::SER_BITS_RESET;
            ser_tx_data_o <= iod_pkg::RESET_BYTE;
        end else if (wr) begin
            unique case (req_i.addr)
                iod_pkg::ADDR_PORT_A: port_a_o <= req_i.wdata;
                iod_pkg::ADDR_PORT_B: port_b_o <= req_i.wdata;
                iod_pkg::ADDR_PORT_C: port_c_o <= req_i.wdata;
                iod_pkg::ADDR_PORT_D: port_d_o <= req_i.wdata;
                iod_pkg::ADDR_IRQ_ENABLES: irq_enables_o <= req_i.wdata;
                iod_pkg::ADDR_MODE_CTRL: mode_ctrl_o <= req_i.wdata;
                iod_pkg::ADDR_SER_CTRL: ser_ctrl_o <= req_i.wdata;
                iod_pkg::ADDR_SER_STATUS: begin
                    ser_status_bits_o <= req_i.wdata[iod_pkg::SER_WR_BIT_HI:iod_pkg::SER_WR_BIT_LO];
                end
                iod_pkg::ADDR_SER_DATA: ser_tx_data_o <= req_i.wdata;
                default: begin
                end
            endcase
        end
    end

    // Serial side effects: one-cycle pulses to the serial unit
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ser_rx_read_o <= 1'b0;
            ser_tx_load_o <= 1'b0;
        end else begin
            ser_rx_read_o <= rd && (req_i.addr == iod_pkg::ADDR_SER_DATA);
            ser_tx_load_o <= wr && (req_i.addr == iod_pkg::ADDR_SER_DATA);
        end
    end

    // ************************************************************
    // Timer latches and strobes
    // ************************************************************
    // Latch C takes the latch with the new upper byte already merged in
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            t1_latch_o <= '0;
            t2_latch_o <= '0;
            t2_latch_c_o <= '0;
        end else if (wr) begin
            unique case (req_i.addr)
                iod_pkg::ADDR_T1_LATCH_LO: t1_latch_o.lo <= req_i.wdata;
                iod_pkg::ADDR_T1_LOW_CLR: t1_latch_o.hi <= req_i.wdata;
                iod_pkg::ADDR_T1_HIGH_LOAD: t1_latch_o.hi <= req_i.wdata;
                iod_pkg::ADDR_T2_LATCH_LO: t2_latch_o.lo <= req_i.wdata;
                iod_pkg::ADDR_T2_LOW_CLR: begin
                    t2_latch_o.hi <= req_i.wdata;
                    t2_latch_c_o <= {req_i.wdata, t2_latch_o.lo};
                end
                iod_pkg::ADDR_T2_HIGH_LOAD: t2_latch_o.hi <= req_i.wdata;
                default: begin
                end
            endcase
        end
    end

    // Load and flag-clear pulses; the timers let a same-cycle underflow win
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            t1_cmd_o <= '0;
            t2_cmd_o <= '0;
        end else begin
            t1_cmd_o.load <= wr && (req_i.addr == iod_pkg::ADDR_T1_HIGH_LOAD);
            t1_cmd_o.flag_clr <= (wr && (req_i.addr == iod_pkg::ADDR_T1_HIGH_LOAD))
                || (rd && (req_i.addr == iod_pkg::ADDR_T1_LOW_CLR));
            t2_cmd_o.load <= wr && (req_i.addr == iod_pkg::ADDR_T2_HIGH_LOAD);
            t2_cmd_o.flag_clr <= (wr && (req_i.addr == iod_pkg::ADDR_T2_HIGH_LOAD))
                || (rd && (req_i.addr == iod_pkg::ADDR_T2_LOW_CLR));
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    property p_t2_reload;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (wr && req_i.addr == iod_pkg::ADDR_T2_HIGH_LOAD)
            |=> (t2_cmd_o.load && t2_cmd_o.flag_clr && t2_latch_o.hi == $past(req_i.wdata));
    endproperty
    a_t2_reload: assert property (p_t2_reload) else $error("timer two reload missing");

    property p_t2_latch_c;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (wr && req_i.addr == iod_pkg::ADDR_T2_LOW_CLR)
            |=> (t2_latch_c_o == {$past(req_i.wdata), t2_latch_o.lo} && !t2_cmd_o.load);
    endproperty
    a_t2_latch_c: assert property (p_t2_latch_c) else $error("latch C copy wrong");

    property p_t1_upper_only;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (wr && (req_i.addr == iod_pkg::ADDR_T1_LOW_CLR || req_i.addr == iod_pkg::ADDR_T1_LATCH_LO))
            |=> (!t1_cmd_o.load && !t1_cmd_o.flag_clr);
    endproperty
    a_t1_upper_only: assert property (p_t1_upper_only) else $error("timer one loaded by latch write");

    property p_t1_reload;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (wr && req_i.addr == iod_pkg::ADDR_T1_HIGH_LOAD) |=> (t1_cmd_o.load && t1_cmd_o.flag_clr)
            // Back-to-back reload writes are legal, so a second pulse is fine only after a second write
            ##1 (!t1_cmd_o.load || $past(wr && req_i.addr == iod_pkg::ADDR_T1_HIGH_LOAD));
    endproperty
    a_t1_reload: assert property (p_t1_reload) else $error("timer one reload pulse wrong");

    property p_t2_read_clr;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (rd && req_i.addr == iod_pkg::ADDR_T2_LOW_CLR)
            |=> (ack_o && rdata_o == $past(t2_count_i.lo) && t2_cmd_o.flag_clr && !t2_cmd_o.load);
    endproperty
    a_t2_read_clr: assert property (p_t2_read_clr) else $error("timer two read clear wrong");

    property p_t1_read_hi;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (rd && req_i.addr == iod_pkg::ADDR_T1_HIGH_LOAD)
            |=> (rdata_o == $past(t1_count_i.hi) && !t1_cmd_o.flag_clr);
    endproperty
    a_t1_read_hi: assert property (p_t1_read_hi) else $error("timer one high read wrong");

    property p_ser_data;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (wr && req_i.addr == iod_pkg::ADDR_SER_DATA)
            |=> (ser_tx_load_o && !ser_rx_read_o && ser_tx_data_o == $past(req_i.wdata));
    endproperty
    a_ser_data: assert property (p_ser_data) else $error("transmit data write wrong");

    property p_ser_status;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (wr && req_i.addr == iod_pkg::ADDR_SER_STATUS)
            |=> (ser_status_bits_o == $past(req_i.wdata[5:4]) && $stable(ser_ctrl_o));
    endproperty
    a_ser_status: assert property (p_ser_status) else $error("status write bits wrong");

    property p_mode_rw;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (wr && req_i.addr == iod_pkg::ADDR_MODE_CTRL) ##1 (rd && req_i.addr == iod_pkg::ADDR_MODE_CTRL)
            |=> (rdata_o == $past(req_i.wdata, 2));
    endproperty
    a_mode_rw: assert property (p_mode_rw) else $error("mode control readback wrong");

    property p_ext_read;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (rd && is_ext) |=> (ext_rd_o && busy_o && !ack_o) [*3] ##1 (ack_o && !ext_rd_o);
    endproperty
    a_ext_read: assert property (p_ext_read) else $error("external read cycle wrong");

    // A request offered while an external read waits must leave no trace
    property p_busy_refuse;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (req_i.sel && busy_o) |=> (!ext_wr_o && !ser_tx_load_o && $stable(port_a_o));
    endproperty
    a_busy_refuse: assert property (p_busy_refuse) else $error("request taken while busy");

    property p_all_ones;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (rd && req_i.addr == iod_pkg::ADDR_ALL_ONES) |=> (ack_o && rdata_o == 8'hff);
    endproperty
    a_all_ones: assert property (p_all_ones) else $error("all-ones read wrong");

    property p_port_write;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (wr && req_i.addr == iod_pkg::ADDR_PORT_C) |=> (port_c_o == $past(req_i.wdata) && !ext_wr_o);
    endproperty
    a_port_write: assert property (p_port_write) else $error("port write wrong");

    c_t2_reload: cover property (@(posedge core_clk_i) disable iff (!nrst_i) t2_cmd_o.load);
    c_ext_read: cover property (@(posedge core_clk_i) disable iff (!nrst_i) (ext_wait_reg == 2'h1));
    c_t1_read_clr: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
        (rd && req_i.addr == iod_pkg::ADDR_T1_LOW_CLR));
    c_ext_write: cover property (@(posedge core_clk_i) disable iff (!nrst_i) ext_wr_o);

endmodule : iod_regs

// ===== tb/iod_ext_model.sv
`timescale 1ns/100ps
// ************************************************************
// External data bus device: a small byte memory
// ************************************************************
module iod_ext_model (
    input wire logic core_clk_i,
    input wire logic ext_rd_i,
    input wire logic ext_wr_i,
    input wire logic [4:0] ext_addr_i,
    input wire logic [7:0] ext_wdata_i,
    output logic [7:0] ext_rdata_o
);
    logic [7:0] mem_reg [0:31];
    logic [7:0] last_reg = 8'h00;
    // Keep bytes written over the external bus
    always @(posedge core_clk_i) begin
        if (ext_wr_i === 1'b1) begin
            mem_reg[ext_addr_i] <= ext_wdata_i;
        end
        if (ext_rd_i === 1'b1) begin
            last_reg <= mem_reg[ext_addr_i];
        end
    end
    // Outside a read strobe the bus shows the inverse, so a late sample is caught
    assign ext_rdata_o = (ext_rd_i === 1'b1) ? mem_reg[ext_addr_i] : ~last_reg;
endmodule : iod_ext_model

// ===== tb/iod_regs_tb.sv
`timescale 1ns/100ps
module iod_regs_tb;
    logic core_clk_i, nrst_i, busy_o, ack_o, ext_rd_o, ext_wr_o, ser_rx_read_o, ser_tx_load_o;
    iod_pkg::iod_req_t req_i;
    logic [4:0] ext_addr_o;
    logic [1:0] ser_status_bits_o;
    logic [7:0] rdata_o, ext_wdata_o, ext_rdata_i, irq_flags_i, ser_status_i, ser_rx_data_i, ser_tx_data_o;
    logic [7:0] rw_out [7];
    iod_pkg::iod_word_t lat [2];
    iod_pkg::iod_word_t cnt [2];
    iod_pkg::iod_word_t t2_latch_c_o;
    iod_pkg::iod_tmr_cmd_t cmd [2];
    logic [7:0] exp_q [$];
    int n_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    iod_regs u_iod_regs (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .req_i(req_i), .busy_o(busy_o),
        .ack_o(ack_o), .rdata_o(rdata_o), .ext_rd_o(ext_rd_o), .ext_wr_o(ext_wr_o), .ext_addr_o(ext_addr_o),
        .ext_wdata_o(ext_wdata_o), .ext_rdata_i(ext_rdata_i), .port_a_o(rw_out[0]), .port_b_o(rw_out[1]),
        .port_c_o(rw_out[2]), .port_d_o(rw_out[3]), .irq_flags_i(irq_flags_i), .irq_enables_o(rw_out[4]),
        .mode_ctrl_o(rw_out[5]), .ser_ctrl_o(rw_out[6]), .ser_status_i(ser_status_i),
        .ser_status_bits_o(ser_status_bits_o), .ser_rx_data_i(ser_rx_data_i), .ser_rx_read_o(ser_rx_read_o),
        .ser_tx_data_o(ser_tx_data_o), .ser_tx_load_o(ser_tx_load_o), .t1_latch_o(lat[0]), .t1_cmd_o(cmd[0]),
        .t1_count_i(cnt[0]), .t2_latch_o(lat[1]), .t2_latch_c_o(t2_latch_c_o), .t2_cmd_o(cmd[1]),
        .t2_count_i(cnt[1]));
    iod_ext_model u_iod_ext_model (.core_clk_i(core_clk_i), .ext_rd_i(ext_rd_o), .ext_wr_i(ext_wr_o),
        .ext_addr_i(ext_addr_o), .ext_wdata_i(ext_wdata_o), .ext_rdata_o(ext_rdata_i));
    // ************************************************************
    // Clock, timeout and verdict
    // ************************************************************
    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end
    task automatic print_verdict;
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict
    // Whole run needs well under 1000 cycles; a hang ends here
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles >= 3000) begin
            n_errors++;
            $display("unexpected cycle count: expected below 3000, seen %0d", cycles);
            print_verdict();
        end
    end
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask : chk
    // One access: note the expected read data, drive at a falling edge, wait out busy
    task automatic acc(input logic wr, input logic [4:0] addr, input logic [7:0] wd, input logic [7:0] exp);
        int n;
        exp_q.push_back(exp);
        @(negedge core_clk_i);
        req_i = '{sel: 1'b1, wr: wr, addr: addr, wdata: wd};
        @(negedge core_clk_i);
        req_i.sel = 1'b0;
        n = 0;
        while (busy_o !== 1'b0 && n < 10) begin
            @(negedge core_clk_i);
            n++;
        end
    endtask : acc
    // Every acknowledge consumes the oldest noted read value
    always @(posedge core_clk_i) begin
        if (ack_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_errors++;
                $display("unexpected ack_o: expected 0, seen 1");
            end else begin
                chk("rdata_o", {8'h00, exp_q.pop_front()}, {8'h00, rdata_o});
            end
        end
    end
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        logic [4:0] rw_addr [7];
        logic [4:0] b;
        logic [7:0] d;
        logic [7:0] lo;
        logic [7:0] hi;
        rw_addr = '{iod_pkg::ADDR_PORT_A, iod_pkg::ADDR_PORT_B, iod_pkg::ADDR_PORT_C, iod_pkg::ADDR_PORT_D,
            iod_pkg::ADDR_IRQ_ENABLES, iod_pkg::ADDR_MODE_CTRL, iod_pkg::ADDR_SER_CTRL};
        void'($urandom(32'h79734c28));
        nrst_i = 1'b0;
        req_i = '0;
        irq_flags_i = $urandom;
        ser_status_i = $urandom;
        ser_rx_data_i = $urandom;
        cnt[0] = $urandom;
        cnt[1] = $urandom;
        repeat (8) @(negedge core_clk_i);
        nrst_i = 1'b1;
        // Plain read/write registers, each written then read back
        for (int i = 0; i < 7; i++) begin
            d = $urandom;
            acc(1'b1, rw_addr[i], d, 8'h00);
            chk("register output", {8'h00, d}, {8'h00, rw_out[i]});
            acc(1'b0, rw_addr[i], 8'h00, d);
        end
        // Mode control written and read back on consecutive cycles
        d = $urandom;
        exp_q.push_back(8'h00);
        exp_q.push_back(d);
        @(negedge core_clk_i);
        req_i = '{sel: 1'b1, wr: 1'b1, addr: iod_pkg::ADDR_MODE_CTRL, wdata: d};
        @(negedge core_clk_i);
        req_i.wr = 1'b0;
        @(negedge core_clk_i);
        req_i.sel = 1'b0;
        // Fixed and read-only places ignore writes
        acc(1'b1, iod_pkg::ADDR_ALL_ONES, 8'h00, 8'h00);
        acc(1'b0, iod_pkg::ADDR_ALL_ONES, 8'h00, 8'hff);
        acc(1'b1, iod_pkg::ADDR_IRQ_FLAGS, ~irq_flags_i, 8'h00);
        acc(1'b0, iod_pkg::ADDR_IRQ_FLAGS, 8'h00, irq_flags_i);
        acc(1'b1, 5'h13, 8'ha5, 8'h00);
        acc(1'b0, 5'h13, 8'h00, 8'h00);
        // Serial status keeps all but bits 5:4 from the serial unit
        d = $urandom;
        acc(1'b1, iod_pkg::ADDR_SER_STATUS, d, 8'h00);
        chk("ser_status_bits_o", {14'h0, d[5:4]}, {14'h0, ser_status_bits_o});
        acc(1'b0, iod_pkg::ADDR_SER_STATUS, 8'h00, {ser_status_i[7:6], d[5:4], ser_status_i[3:0]});
        acc(1'b1, iod_pkg::ADDR_SER_DATA, d, 8'h00);
        chk("ser_tx", {7'h0, 1'b1, d}, {7'h0, ser_tx_load_o, ser_tx_data_o});
        acc(1'b0, iod_pkg::ADDR_SER_DATA, 8'h00, ser_rx_data_i);
        chk("ser strobes", 16'h0001, {14'h0, ser_tx_load_o, ser_rx_read_o});
        // Both timer groups share one walk, base 0x18 and 0x1c
        for (int t = 0; t < 2; t++) begin
            b = t ? iod_pkg::ADDR_T2_LATCH_LO : iod_pkg::ADDR_T1_LATCH_LO;
            lo = $urandom;
            hi = $urandom;
            acc(1'b1, b, lo, 8'h00);
            chk("latch low", {6'h00, lo, 2'b00}, {6'h00, lat[t].lo, cmd[t]});
            acc(1'b1, b + 5'h1, hi, 8'h00);
            chk("latch", {hi, lo}, lat[t]);
            chk("cmd", 16'h0, {14'h0, cmd[t]});
            if (t == 1) chk("latch c", {hi, lo}, t2_latch_c_o);
            d = $urandom;
            acc(1'b1, b + 5'h2, d, 8'h00);
            chk("load", {d, 8'h03}, {lat[t].hi, 6'h0, cmd[t]});
            acc(1'b0, b + 5'h3, 8'h00, cnt[t].lo);
            acc(1'b0, b + 5'h2, 8'h00, cnt[t].hi);
            chk("cmd", 16'h0, {14'h0, cmd[t]});
            acc(1'b0, b + 5'h1, 8'h00, cnt[t].lo);
            chk("flag clear", 16'h1, {14'h0, cmd[t]});
            acc(1'b0, b, 8'h00, 8'h00);
        end
        // Every external address: write a strobe, then read back through the bus
        for (int a = 4; a < 16; a++) begin
            d = $urandom;
            acc(1'b1, a[4:0], d, 8'h00);
            chk("ext write", {2'b01, a[4:0], 1'b0, d}, {1'b0, ext_wr_o, ext_addr_o, 1'b0, ext_wdata_o});
            acc(1'b0, a[4:0], 8'h00, d);
        end
        // A port write offered while an external read waits is dropped
        lo = $urandom;
        acc(1'b1, iod_pkg::ADDR_PORT_A, lo, 8'h00);
        exp_q.push_back(d);
        @(negedge core_clk_i);
        req_i = '{sel: 1'b1, wr: 1'b0, addr: iod_pkg::ADDR_EXT_LAST, wdata: 8'h00};
        @(negedge core_clk_i);
        req_i = '{sel: 1'b1, wr: 1'b1, addr: iod_pkg::ADDR_PORT_A, wdata: ~lo};
        chk("busy_o", 16'h1, {15'h0, busy_o});
        repeat (2) @(negedge core_clk_i);
        req_i.sel = 1'b0;
        repeat (2) @(negedge core_clk_i);
        chk("port a while busy", {8'h00, lo}, {8'h00, rw_out[0]});
        repeat (2) @(negedge core_clk_i);
        chk("pending acks", 16'h0, 16'(exp_q.size()));
        print_verdict();
    end
endmodule : iod_regs_tb
